// File: ffr_pkg.sv
// package of constants and carrier types for the flip-flop register file
package ffr_pkg;
  localparam int FFR_WORD_W = 16;
  localparam int FFR_ADDR_W = 12;
  // octal 0017 is the last special-register address
  localparam logic [11:0] FFR_SPECIAL_LAST = 12'h00f;
  localparam logic [11:0] FFR_ADDR_ACC = 12'h000;
  localparam logic [11:0] FFR_ADDR_RETURN = 12'h001;
  localparam logic [11:0] FFR_ADDR_PC = 12'h002;
  localparam logic [11:0] FFR_ADDR_LOW_PRODUCT = 12'h003;
  localparam logic [15:0] FFR_RESET_WORD = 16'h0000;
  // bit position 14 of the low-product register, index 13 zero based
  localparam int FFR_LP_CARRY_BIT = 13;

  // write and read control pulses from the sequence generator, one action wide
  typedef struct packed {
    logic addr_reg_write_pulse;
    logic addr_reg_read_pulse;
    logic acc_write_pulse;
    logic acc_read_pulse;
    logic shift_pair_write_pulse;
    logic return_write_pulse;
    logic return_read_pulse;
    logic pc_write_pulse;
    logic pc_read_pulse;
    logic lp_write_pulse;
    logic lp_read_pulse;
    logic buffer_write_pulse;
    logic buffer_read_pulse;
    logic buffer_complement_pulse;
    logic order_fetch_read;
  } ffr_ctl_t;

  // timing phases from the timer, sampled once per action
  typedef struct packed {
    logic phase_234;
    logic phase_12;
  } ffr_phase_t;
endpackage

// File: ffr_register_file.sv
// central processor flip-flop register file with addressable register decode
`timescale 1ns/1ps
// Contract
// (RULE1) addressable write and read pulses gated with phase 234 give write/read strobes
// (RULE2) addressable write pulse gated with phase 12 gives the clear strobe
// (RULE3) special-register select is active for addresses octal 0000 through 0017
// (RULE4) special-register select inhibits erasable memory cycle timing
// (RULE5) above octal 0017 select drops, memory timing enabled, addressable gates off
// (RULE6) accumulator holds, loads all write lines on write, drives them on read
// (RULE7) shift-pair write loads accumulator bit n from write line n+1
// (RULE8) shift-pair write copies the sign line into accumulator bits 15 and 16
// (RULE9) shift-pair write loads write line 1 into low-product bit 14
// (RULE10) return register loads each write line into the same position
// (RULE11) return register keeps a transfer-control return address until rewritten
// (RULE12) return register holds dividend and then remainder during divide
// (RULE13) program counter holds next address, rewritten with adder increment
// (RULE14) low-product register pairs with accumulator as double-length shifter
// (RULE15) shift-pair write loads low-product with the word rotated right by one; the code puts line 1 into bits 14..16 and drops lines 15 and 16
// (RULE16) buffer register stores order code and operand address of next instruction
// (RULE17) buffer register ignores the addressable decode, uses its own strobes only
// (RULE18) buffer true read is buffer pulse with phase 234, or order-fetch read
// (RULE19) order-fetch read drives buffer content onto the write lines
// (RULE20) complement read drives the inverted buffer content onto the write lines
// (RULE21) every register is 16 bits, one slice per bit position
// (RULE22) a register clears only with its write, otherwise retains until next write
// (RULE23) reads never change register content
// (RULE24) addresses 0000..0003 select accumulator, return, counter, low-product
// (RULE25) each action is one clock; writes load at cycle end, reads drive in-cycle
// (RULE26) reset clears every register to zero
module ffr_register_file
  import ffr_pkg::*;
#(
  parameter int WORD_W = FFR_WORD_W,
  parameter int ADDR_W = FFR_ADDR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ffr_ctl_t ctl,
  input wire ffr_phase_t phase,
  input wire logic [ADDR_W-1:0] mem_address,
  input wire logic [WORD_W-1:0] write_line_in,
  output logic [WORD_W-1:0] write_line_out,
  output logic special_register_select,
  output logic erasable_cycle_inhibit,
  output logic [WORD_W-1:0] accumulator_reg,
  output logic [WORD_W-1:0] return_remainder_reg,
  output logic [WORD_W-1:0] program_counter_reg,
  output logic [WORD_W-1:0] low_product_reg,
  output logic [WORD_W-1:0] buffer_reg
);

  // the bit slicing of the shift path is fixed to the documented word, so refuse anything else at elaboration
  generate
    if (WORD_W != FFR_WORD_W) begin : g_bad_word
      $error("ffr_register_file supports only a 16-bit word");
    end
    if (ADDR_W != FFR_ADDR_W) begin : g_bad_addr
      $error("ffr_register_file supports only a 12-bit address");
    end
    if (FFR_LP_CARRY_BIT >= WORD_W) begin : g_bad_carry
      $error("ffr_register_file carry slot lies outside the word");
    end
  endgenerate

  // addressable strobes and register selects
  logic addr_reg_write_strobe;
  logic addr_reg_read_strobe;
  logic addr_reg_clear_strobe;
  logic sel_acc;
  logic sel_return;
  logic sel_pc;
  logic sel_lp;

  // per-register service strobes
  logic acc_write_strobe;
  logic acc_read_strobe;
  logic acc_clear_strobe;
  logic shift_pair_write_strobe;
  logic return_reg_write_strobe;
  logic return_read_strobe;
  logic return_clear_strobe;
  logic pc_write_strobe;
  logic pc_read_strobe;
  logic pc_clear_strobe;
  logic lp_write_strobe;
  logic lp_read_strobe;
  logic lp_clear_strobe;
  logic buffer_write_strobe;
  logic buffer_clear_strobe;
  logic buffer_true_read_strobe;
  logic buffer_complement_read_strobe;

  // next values and the second write-gate wiring of the slices
  logic [WORD_W-1:0] acc_next;
  logic [WORD_W-1:0] return_next;
  logic [WORD_W-1:0] pc_next;
  logic [WORD_W-1:0] lp_next;
  logic [WORD_W-1:0] buffer_next;
  logic [WORD_W-1:0] lp_rotated;
  logic [WORD_W-1:0] acc_shifted;

  // special-register decode; the whole address is compared against 0017, so 0000..0017 all match
  assign special_register_select = (mem_address <= FFR_SPECIAL_LAST); // RULE3 RULE5
  // memory timing is held off so the cycle serves the register instead
  assign erasable_cycle_inhibit = special_register_select; // RULE4

  // addressable strobes; the select gates them so addresses above 0017 do nothing here
  assign addr_reg_write_strobe = ctl.addr_reg_write_pulse & phase.phase_234 & special_register_select; // RULE1 RULE5
  assign addr_reg_read_strobe = ctl.addr_reg_read_pulse & phase.phase_234 & special_register_select; // RULE1 RULE5
  assign addr_reg_clear_strobe = ctl.addr_reg_write_pulse & phase.phase_12 & special_register_select; // RULE2

  // address 0000..0003 picks one of the four program-addressable registers
  assign sel_acc = (mem_address == FFR_ADDR_ACC); // RULE24
  assign sel_return = (mem_address == FFR_ADDR_RETURN); // RULE24
  assign sel_pc = (mem_address == FFR_ADDR_PC); // RULE24
  assign sel_lp = (mem_address == FFR_ADDR_LOW_PRODUCT); // RULE24

  // per-register service gates: own pulse with 234 (with 12 for the clear), or the addressable path
  assign acc_write_strobe = (ctl.acc_write_pulse & phase.phase_234) | (addr_reg_write_strobe & sel_acc);
  assign acc_read_strobe = (ctl.acc_read_pulse & phase.phase_234) | (addr_reg_read_strobe & sel_acc);
  assign acc_clear_strobe = (ctl.acc_write_pulse & phase.phase_12) | (addr_reg_clear_strobe & sel_acc);

  // shift-pair has no clear of its own: the slices overwrite every bit anyway
  assign shift_pair_write_strobe = ctl.shift_pair_write_pulse & phase.phase_234; // RULE15

  // return register service gates
  assign return_reg_write_strobe = (ctl.return_write_pulse & phase.phase_234) | (addr_reg_write_strobe & sel_return);
  assign return_read_strobe = (ctl.return_read_pulse & phase.phase_234) | (addr_reg_read_strobe & sel_return);
  assign return_clear_strobe = (ctl.return_write_pulse & phase.phase_12) | (addr_reg_clear_strobe & sel_return);

  // program counter service gates
  assign pc_write_strobe = (ctl.pc_write_pulse & phase.phase_234) | (addr_reg_write_strobe & sel_pc);
  assign pc_read_strobe = (ctl.pc_read_pulse & phase.phase_234) | (addr_reg_read_strobe & sel_pc);
  assign pc_clear_strobe = (ctl.pc_write_pulse & phase.phase_12) | (addr_reg_clear_strobe & sel_pc);

  // low-product service gates
  assign lp_write_strobe = (ctl.lp_write_pulse & phase.phase_234) | (addr_reg_write_strobe & sel_lp);
  assign lp_read_strobe = (ctl.lp_read_pulse & phase.phase_234) | (addr_reg_read_strobe & sel_lp);
  assign lp_clear_strobe = (ctl.lp_write_pulse & phase.phase_12) | (addr_reg_clear_strobe & sel_lp);

  // buffer register sees no addressable term at all
  assign buffer_write_strobe = ctl.buffer_write_pulse & phase.phase_234; // RULE17
  assign buffer_clear_strobe = ctl.buffer_write_pulse & phase.phase_12; // RULE17
  assign buffer_true_read_strobe = (ctl.buffer_read_pulse & phase.phase_234) | ctl.order_fetch_read; // RULE18 RULE19
  assign buffer_complement_read_strobe = ctl.buffer_complement_pulse & phase.phase_234; // RULE20

  // one slice per bit position; only the second write gates differ between slices
  // low-product: bits 1..13 from lines 2..14, bits 14..16 from line 1; lines 15 and 16 are dropped
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < WORD_W; bit_idx++) begin : g_slice
      logic acc_shift_src;
      logic lp_shift_src;
      // accumulator second gate: next line up, the top slice repeats the sign line
      if (bit_idx < WORD_W - 1) begin : g_acc_low
        assign acc_shift_src = write_line_in[bit_idx + 1]; // RULE7
      end else begin : g_acc_sign
        assign acc_shift_src = write_line_in[WORD_W - 1]; // RULE8
      end
      // low-product gate: next line up below the carry slot, line 1 from there on
      if (bit_idx < FFR_LP_CARRY_BIT) begin : g_lp_low
        assign lp_shift_src = write_line_in[bit_idx + 1]; // RULE15
      end else begin : g_lp_carry
        assign lp_shift_src = write_line_in[0]; // RULE9
      end
      assign acc_shifted[bit_idx] = acc_shift_src; // RULE21
      assign lp_rotated[bit_idx] = lp_shift_src; // RULE21
    end
  endgenerate

  // accumulator next value; shift-pair wins over a plain write since both reach one flop
  always_comb begin
    acc_next = accumulator_reg; // RULE22 RULE23
    if (acc_clear_strobe) begin
      acc_next = FFR_RESET_WORD; // RULE22
    end
    if (shift_pair_write_strobe) begin
      acc_next = acc_shifted; // RULE7 RULE8 RULE14
    end else if (acc_write_strobe) begin
      acc_next = write_line_in; // RULE6
    end
  end

  // return register: straight load; holds return address or dividend/remainder between writes
  always_comb begin
    return_next = return_remainder_reg; // RULE11 RULE12
    if (return_clear_strobe) begin
      return_next = FFR_RESET_WORD; // RULE22
    end
    if (return_reg_write_strobe) begin
      return_next = write_line_in; // RULE10
    end
  end

  // program counter: the adder's incremented word comes back on the write lines
  always_comb begin
    pc_next = program_counter_reg;
    if (pc_clear_strobe) begin
      pc_next = FFR_RESET_WORD; // RULE22
    end
    if (pc_write_strobe) begin
      pc_next = write_line_in; // RULE13
    end
  end

  // low-product register: both its own write and the shift-pair write load the write lines shifted right, line 1 into bits 14..16
  always_comb begin
    lp_next = low_product_reg;
    if (lp_clear_strobe) begin
      lp_next = FFR_RESET_WORD; // RULE22
    end
    if (shift_pair_write_strobe) begin
      lp_next = lp_rotated; // RULE9 RULE14 RULE15
      lp_next[FFR_LP_CARRY_BIT] = write_line_in[0]; // RULE9
    end else if (lp_write_strobe) begin
      lp_next = lp_rotated;
    end
  end

  // buffer register: order code and operand address of the next instruction
  always_comb begin
    buffer_next = buffer_reg;
    if (buffer_clear_strobe) begin
      buffer_next = FFR_RESET_WORD; // RULE22
    end
    if (buffer_write_strobe) begin
      buffer_next = write_line_in; // RULE16
    end
  end

  // accumulator flops; every action is one edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_reg <= FFR_RESET_WORD; // RULE26
    end else begin
      accumulator_reg <= acc_next; // RULE25
    end
  end

  // return register flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      return_remainder_reg <= FFR_RESET_WORD; // RULE26
    end else begin
      return_remainder_reg <= return_next; // RULE25
    end
  end

  // program counter flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_reg <= FFR_RESET_WORD; // RULE26
    end else begin
      program_counter_reg <= pc_next;
    end
  end

  // low-product flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_product_reg <= FFR_RESET_WORD; // RULE26
    end else begin
      low_product_reg <= lp_next;
    end
  end

  // buffer flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_reg <= FFR_RESET_WORD; // RULE26
    end else begin
      buffer_reg <= buffer_next; // RULE21
    end
  end

  // read gates wire-or onto the write lines within the action; a register would cost a cycle
  always_comb begin
    write_line_out = '0;
    if (acc_read_strobe) begin
      write_line_out = write_line_out | accumulator_reg; // RULE6 RULE23
    end
    if (return_read_strobe) begin
      write_line_out = write_line_out | return_remainder_reg;
    end
    if (pc_read_strobe) begin
      write_line_out = write_line_out | program_counter_reg;
    end
    if (lp_read_strobe) begin
      write_line_out = write_line_out | low_product_reg;
    end
    if (buffer_true_read_strobe) begin
      write_line_out = write_line_out | buffer_reg; // RULE19
    end
    if (buffer_complement_read_strobe) begin
      write_line_out = write_line_out | ~buffer_reg; // RULE20
    end
  end

endmodule // ffr_register_file

// File: ffr_register_file_assertions.sv
// port-level checks for the flip-flop register file
`timescale 1ns/1ps
module ffr_register_file_checker
  import ffr_pkg::*;
#(
  parameter int WORD_W = FFR_WORD_W,
  parameter int ADDR_W = FFR_ADDR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ffr_ctl_t ctl,
  input wire ffr_phase_t phase,
  input wire logic [ADDR_W-1:0] mem_address,
  input wire logic [WORD_W-1:0] write_line_in,
  input wire logic [WORD_W-1:0] write_line_out,
  input wire logic special_register_select,
  input wire logic erasable_cycle_inhibit,
  input wire logic [WORD_W-1:0] accumulator_reg,
  input wire logic [WORD_W-1:0] return_remainder_reg,
  input wire logic [WORD_W-1:0] program_counter_reg,
  input wire logic [WORD_W-1:0] low_product_reg,
  input wire logic [WORD_W-1:0] buffer_reg
);
  logic [WORD_W-1:0] wl_q;
  // last action's write lines, kept so load checks need no sliced past value
  always_ff @(posedge mclk) begin
    wl_q <= write_line_in;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sel_decode_a: assert property (special_register_select == (mem_address <= FFR_SPECIAL_LAST))
    else $error("select decode wrong");
  inhibit_tie_a: assert property (erasable_cycle_inhibit == special_register_select)
    else $error("inhibit differs from select");
  acc_load_a: assert property (ctl.acc_write_pulse && phase.phase_234 && !ctl.shift_pair_write_pulse |=>
    accumulator_reg == wl_q) else $error("acc load wrong");
  shift_pair_a: assert property (ctl.shift_pair_write_pulse && phase.phase_234 |=>
    accumulator_reg == {wl_q[15], wl_q[15:1]} && low_product_reg == {{3{wl_q[0]}}, wl_q[13:1]})
    else $error("shift pair wrong");
  acc_read_a: assert property (ctl.acc_read_pulse && phase.phase_234 |->
    (write_line_out & accumulator_reg) == accumulator_reg) else $error("acc read wrong");
  fetch_read_a: assert property (ctl.order_fetch_read |-> (write_line_out & buffer_reg) == buffer_reg)
    else $error("fetch read wrong");
  comp_read_a: assert property (ctl.buffer_complement_pulse && phase.phase_234 |->
    (write_line_out & ~buffer_reg) == ~buffer_reg) else $error("complement read wrong");
  buffer_noaddr_a: assert property (ctl.addr_reg_write_pulse && !ctl.buffer_write_pulse |=>
    $stable(buffer_reg)) else $error("buffer took addressable write");
endmodule // ffr_register_file_checker
bind ffr_register_file ffr_register_file_checker #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) chk_u (.mclk(mclk),
  .rst_n(rst_n), .ctl(ctl), .phase(phase), .mem_address(mem_address), .write_line_in(write_line_in),
  .write_line_out(write_line_out), .special_register_select(special_register_select),
  .erasable_cycle_inhibit(erasable_cycle_inhibit), .accumulator_reg(accumulator_reg),
  .return_remainder_reg(return_remainder_reg), .program_counter_reg(program_counter_reg),
  .low_product_reg(low_product_reg), .buffer_reg(buffer_reg));

// File: ffr_seq_model.sv
// write-line adder model standing for the sequence generator side
`timescale 1ns/1ps
module ffr_seq_model (
  input wire logic [15:0] write_line_out,
  input wire logic [15:0] drive_word,
  input wire logic incr,
  output logic [15:0] write_line_in
);
  // increment passes the bus through the adder, else the injected word joins the bus
  assign write_line_in = incr ? write_line_out + 16'h0001 : (write_line_out | drive_word);
endmodule // ffr_seq_model

// File: tb.sv
// self-checking bench for the flip-flop register file
`timescale 1ns/1ps
module tb
  import ffr_pkg::*;
;
  localparam logic [14:0] aw = 15'h4000, ar = 15'h2000, acw = 15'h1000, acr = 15'h0800, sp = 15'h0400;
  localparam logic [14:0] pw = 15'h0080, pr = 15'h0040, bw = 15'h0008, br = 15'h0004, bc = 15'h0002;
  logic mclk, rst_n, inc_i, sel, inh;
  logic [14:0] ctl_i;
  logic [1:0] ph_i;
  logic [11:0] addr_i;
  logic [15:0] drv_i, wl_in, wl_out, acc, rq, pc, lp, bq;
  int n_mismatch = 0;
  int tests_run = 0;
  ffr_register_file dut_u (.mclk(mclk), .rst_n(rst_n), .ctl(ffr_ctl_t'(ctl_i)), .phase(ffr_phase_t'(ph_i)),
    .mem_address(addr_i), .write_line_in(wl_in), .write_line_out(wl_out), .special_register_select(sel),
    .erasable_cycle_inhibit(inh), .accumulator_reg(acc), .return_remainder_reg(rq),
    .program_counter_reg(pc), .low_product_reg(lp), .buffer_reg(bq));
  ffr_seq_model seq_u (.write_line_out(wl_out), .drive_word(drv_i), .incr(inc_i), .write_line_in(wl_in));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one action: inputs move on the falling edge, reads are judged before the next rise
  task automatic act(input logic [14:0] c, input logic [1:0] p, input logic [11:0] a = 12'h050,
    input logic [15:0] w = 16'h0000, input logic i = 1'b0);
    @(negedge mclk);
    ctl_i = c;
    ph_i = p;
    addr_i = a;
    drv_i = w;
    inc_i = i;
    #1;
  endtask
  task automatic s_acc;
    act(acw, 2'b10, 12'h050, 16'ha5c3);
    act(acr, 2'b10);
    chk(wl_out, 16'ha5c3);
    act(acr, 2'b10);
    chk(acc, 16'ha5c3);
    act(15'h0200, 2'b10, 12'h050, 16'h5a5a);
    act(15'h0100, 2'b10);
    chk(wl_out, 16'h5a5a);
  endtask
  // low-product slot reads back rotated through its own wiring
  task automatic s_addr;
    logic [15:0] exp [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h0222};
    for (int i = 0; i < 4; i++) begin
      act(aw, 2'b11, 12'(i), 16'(16'h1111 * (i + 1)));
      act(ar, 2'b10, 12'(i));
      chk(wl_out, exp[i]);
    end
    act(aw, 2'b11, 12'h010, 16'hffff);
    chk({14'h0000, sel, inh}, 16'h0000);
    act(aw, 2'b11, 12'h00f, 16'hffff);
    chk({14'h0000, sel, inh}, 16'h0003);
    act(aw, 2'b01, 12'h000, 16'hffff);
    chk(acc, 16'h1111);
    act(15'h0000, 2'b00);
    chk(acc, 16'h0000);
  endtask
  task automatic s_shift;
    act(sp, 2'b10, 12'h050, 16'h8001);
    act(sp, 2'b10, 12'h050, 16'h4002);
    chk(acc, 16'hc000);
    chk(lp, 16'he000);
    act(15'h0000, 2'b00);
    chk(acc, 16'h2001);
    chk(lp, 16'h0001);
    act(15'h0010, 2'b10);
    chk(wl_out, 16'h0001);
  endtask
  task automatic s_buf;
    act(bw, 2'b10, 12'h050, 16'h3c5a);
    act(aw, 2'b11, 12'h000, 16'h0f0f);
    act(15'h0001, 2'b00);
    chk(wl_out, 16'h3c5a);
    act(br, 2'b10);
    chk(wl_out, 16'h3c5a);
    act(br, 2'b01);
    chk(wl_out, 16'h0000);
    act(bc, 2'b10);
    chk(wl_out, 16'hc3a5);
  endtask
  // counter goes round the adder twice, back to back
  task automatic s_pc;
    act(pr | pw, 2'b10, 12'h050, 16'h0000, 1'b1);
    chk(wl_out, 16'h3333);
    act(pr | pw, 2'b10, 12'h050, 16'h0000, 1'b1);
    chk(wl_out, 16'h3334);
    act(15'h0000, 2'b00);
    chk(pc, 16'h3335);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    ctl_i = 15'h0000;
    ph_i = 2'b00;
    addr_i = 12'h050;
    drv_i = 16'h0000;
    inc_i = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk(acc | rq | pc | lp | bq, 16'h0000);
    s_acc;
    s_addr;
    s_shift;
    s_buf;
    s_pc;
    end_of_test;
  end
endmodule // tb
